// *** rtl/adcc_map.svh ***
// Constants for the sample capture and power-down block
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_SAMPLE_WIDTH 14
`define ADCC_FIFO_DEPTH 32
`define ADCC_PIPE_DEPTH 4
`define ADCC_DUTY_MIN_PCT 30
`define ADCC_DUTY_MAX_PCT 70
`define ADCC_MID_SCALE 14'h2000
`endif

// *** rtl/adcc_pkg.sv ***
// Types for the sample capture and power-down block
`default_nettype none
package adcc_pkg;
   typedef enum logic [1:0] {
      ADCC_SEL_VA = 2'b11,
      ADCC_SEL_TWO_THIRD = 2'b10,
      ADCC_SEL_ONE_THIRD = 2'b01,
      ADCC_SEL_GND = 2'b00
   } adcc_sel_e;
   typedef enum logic [1:0] {
      ADCC_SLEEP = 2'b00,
      ADCC_FILL = 2'b01,
      ADCC_RUN = 2'b10
   } adcc_state_e;
endpackage
`default_nettype wire

// *** rtl/adcc_fifo.sv ***
// Sample FIFO with valid and ready on both sides
`default_nettype none
module adcc_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready_out = (cnt_q != DEPTH[AW:0]);
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_q];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_ff @(posedge sys_clk_in)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_in;
      end
   end
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else if (flush_in)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule
`default_nettype wire

// *** rtl/adcc_top.sv ***
// Digital side of the converter: sampling, coding, power-down and strobed output
`include "adcc_map.svh"
`default_nettype none
module adcc_top #(
   parameter int WIDTH = `ADCC_SAMPLE_WIDTH,
   parameter int DEPTH = `ADCC_FIFO_DEPTH,
   parameter int PIPE = `ADCC_PIPE_DEPTH
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic sample_clk_in,
   input wire logic sleep_request_in,
   input wire adcc_pkg::adcc_sel_e format_stabilizer_select_in,
   input wire logic [WIDTH-1:0] raw_sample_in,
   output logic [WIDTH-1:0] sample_bits_out,
   output logic sample_strobe_out,
   output logic stabilizer_on_out,
   output logic converting_out,
   output logic overflow_out
);
   import adcc_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [2:0] clk_s1_q;
   logic [2:0] clk_s2_q;
   logic clk_rise;
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         clk_s1_q <= '0;
         clk_s2_q <= '0;
      end
      else
      begin
         clk_s1_q <= {sleep_request_in, format_stabilizer_select_in};
         clk_s2_q <= clk_s1_q;
      end
   end
   logic samp_s1_q;
   logic samp_s2_q;
   logic samp_s3_q;
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         samp_s1_q <= 1'b0;
         samp_s2_q <= 1'b0;
         samp_s3_q <= 1'b0;
      end
      else
      begin
         samp_s1_q <= sample_clk_in;
         samp_s2_q <= samp_s1_q;
         samp_s3_q <= samp_s2_q;
      end
   end
   assign clk_rise = samp_s2_q && !samp_s3_q;
   logic sleep;
   adcc_sel_e sel;
   assign sleep = clk_s2_q[2];
   assign sel = adcc_sel_e'(clk_s2_q[1:0]);

   // Raw data is assumed quasi-static per sample clock; captured on the edge
   logic [WIDTH-1:0] raw_s1_q;
   logic [WIDTH-1:0] raw_s2_q;
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         raw_s1_q <= '0;
         raw_s2_q <= '0;
      end
      else
      begin
         raw_s1_q <= raw_sample_in;
         raw_s2_q <= raw_s1_q;
      end
   end

   // ****************************************
   // Power state and pipeline
   // ****************************************
   adcc_state_e state_q;
   logic [$clog2(PIPE+1)-1:0] fill_q;
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_q <= ADCC_SLEEP;
         fill_q <= '0;
      end
      else if (sleep)
      begin
         state_q <= ADCC_SLEEP;
         fill_q <= '0;
      end
      else
      begin
         unique case (state_q)
            ADCC_SLEEP:
            begin
               state_q <= ADCC_FILL;
            end
            ADCC_FILL:
            begin
               if (clk_rise)
               begin
                  fill_q <= fill_q + 1'b1;
                  if (fill_q == ($clog2(PIPE+1))'(PIPE - 1))
                  begin
                     state_q <= ADCC_RUN;
                  end
               end
            end
            ADCC_RUN:
            begin
               state_q <= ADCC_RUN;
            end
         endcase
      end
   end

   // Coding select: top bit inverted for two's complement
   logic twos;
   assign twos = (sel == ADCC_SEL_VA) || (sel == ADCC_SEL_TWO_THIRD);
   logic [WIDTH-1:0] coded;
   assign coded = raw_s2_q ^ (twos ? `ADCC_MID_SCALE : '0);

   logic [WIDTH-1:0] pipe_q [PIPE];
   genvar g;
   generate
      for (g = 0; g < PIPE; g++)
      begin : g_pipe
         always_ff @(posedge sys_clk_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
            begin
               pipe_q[g] <= '0;
            end
            else if (clk_rise && !sleep)
            begin
               pipe_q[g] <= (g == 0) ? coded : pipe_q[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   // ****************************************
   // Output FIFO and strobe
   // ****************************************
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [WIDTH-1:0] fifo_out_data;
   logic pop_q;
   logic push;
   assign push = clk_rise && (state_q == ADCC_RUN) && !sleep;
   adcc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .flush_in(sleep),
      .in_valid_in(push),
      .in_ready_out(fifo_in_ready),
      .in_data_in(pipe_q[PIPE-1]),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(pop_q),
      .out_data_out(fifo_out_data)
   );

   // Strobe phase: data set up low, strobe high one cycle later, held two cycles
   logic [1:0] ph_q;
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ph_q <= 2'h0;
         pop_q <= 1'b0;
         sample_bits_out <= '0;
         sample_strobe_out <= 1'b0;
         overflow_out <= 1'b0;
      end
      else
      begin
         pop_q <= 1'b0;
         overflow_out <= sleep ? 1'b0 : (overflow_out || (push && !fifo_in_ready));
         if (sleep)
         begin
            ph_q <= 2'h0;
            sample_strobe_out <= 1'b0;
         end
         else
         begin
            unique case (ph_q)
               2'h0:
               begin
                  if (fifo_out_valid && !pop_q)
                  begin
                     sample_bits_out <= fifo_out_data;
                     pop_q <= 1'b1;
                     ph_q <= 2'h1;
                  end
               end
               2'h1:
               begin
                  sample_strobe_out <= 1'b1;
                  ph_q <= 2'h2;
               end
               2'h2:
               begin
                  ph_q <= 2'h3;
               end
               2'h3:
               begin
                  sample_strobe_out <= 1'b0;
                  ph_q <= 2'h0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         stabilizer_on_out <= 1'b0;
         converting_out <= 1'b0;
      end
      else
      begin
         stabilizer_on_out <= (sel == ADCC_SEL_TWO_THIRD) || (sel == ADCC_SEL_ONE_THIRD);
         converting_out <= (state_q == ADCC_RUN) && !sleep;
      end
   end
endmodule
`default_nettype wire

// *** verif/adcc_chk.sv ***
// Port assertions for the converter block
`default_nettype none
module adcc_chk #(
   parameter int WIDTH = 14
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic sleep_request_in,
   input wire adcc_pkg::adcc_sel_e format_stabilizer_select_in,
   input wire logic [WIDTH-1:0] sample_bits_out,
   input wire logic sample_strobe_out,
   input wire logic stabilizer_on_out,
   input wire logic converting_out,
   input wire logic overflow_out
);
   import adcc_pkg::*;
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   sequence pulse_s;
      sample_strobe_out [*2] ##1 !sample_strobe_out [*2];
   endsequence
   // Select held and out of reset long enough to pass the synchroniser
   sequence settled_s;
      ($stable(format_stabilizer_select_in) && $past(reset_n_in)) [*4];
   endsequence
   asleep_quiet_a: assert property (sleep_request_in [*6] |-> !sample_strobe_out && !converting_out)
      else $error("output active while asleep");
   sleep_flush_a: assert property (sleep_request_in [*6] |-> !overflow_out)
      else $error("overflow kept while asleep");
   strobe_awake_a: assert property ($rose(sample_strobe_out) |-> converting_out)
      else $error("strobe while not converting");
   // Sleep may cut a pulse short; the outputs carry no meaning then
   strobe_shape_a: assert property (disable iff (!reset_n_in || sleep_request_in)
      $rose(sample_strobe_out) |-> pulse_s)
      else $error("strobe pulse malformed");
   word_hold_a: assert property (sample_strobe_out |-> $stable(sample_bits_out))
      else $error("word changed under strobe");
   stab_map_a: assert property (settled_s |-> stabilizer_on_out ==
      (format_stabilizer_select_in[1] ^ format_stabilizer_select_in[0]))
      else $error("stabilizer flag wrong");
endmodule
`default_nettype wire

// *** verif/adcc_capture.sv ***
// Capture logic model on the far side of the parallel port
`default_nettype none
module adcc_capture #(
   parameter int WAKE = 200
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic sleep_request_in,
   input wire logic [13:0] sample_bits_in,
   input wire logic sample_strobe_in,
   output logic [13:0] word_out,
   output logic word_valid_out,
   output int words_out
);
   int wake_q;
   // Words are taken on the strobe edge, never on the system clock
   always_ff @(posedge sample_strobe_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         word_out <= 14'h0;
         word_valid_out <= 1'b0;
         words_out <= 0;
      end
      else
      begin
         word_out <= sample_bits_in;
         word_valid_out <= !sleep_request_in && wake_q >= WAKE;
         words_out <= words_out + 1;
      end
   end
   // Recovery interval restarts on every sleep
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         wake_q <= 0;
      else if (sleep_request_in)
         wake_q <= 0;
      else if (wake_q < WAKE)
         wake_q <= wake_q + 1;
   end
endmodule
`default_nettype wire

// *** verif/adcc_top_tb.sv ***
// Testbench for the converter block
`default_nettype none
module adcc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import adcc_pkg::*;
   localparam logic [13:0] RAWS [4] = '{14'h2000, 14'h0000, 14'h3fff, 14'h1000};
   logic clk, rst_n, sclk, sclk_run, sleep, strobe, stab, conv, ovf, cap_valid;
   adcc_sel_e sel;
   logic [13:0] raw, bits, cap_word;
   int cap_n, miscompares, n_compared;
   adcc_top #(.WIDTH(14), .DEPTH(32), .PIPE(4)) adcc_top_inst (.sys_clk_in(clk), .reset_n_in(rst_n),
      .sample_clk_in(sclk), .sleep_request_in(sleep), .format_stabilizer_select_in(sel),
      .raw_sample_in(raw), .sample_bits_out(bits), .sample_strobe_out(strobe),
      .stabilizer_on_out(stab), .converting_out(conv), .overflow_out(ovf));
   adcc_capture #(.WAKE(200)) adcc_capture_inst (.sys_clk_in(clk), .reset_n_in(rst_n),
      .sleep_request_in(sleep), .sample_bits_in(bits), .sample_strobe_in(strobe),
      .word_out(cap_word), .word_valid_out(cap_valid), .words_out(cap_n));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Sample clock runs while enabled and rests low otherwise
   initial
   begin
      sclk = 1'b0;
      #7;
      forever #80 sclk = sclk_run ? ~sclk : 1'b0;
   end
   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish(input bit hung);
      if (hung)
         miscompares++;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wait_words(input int n);
      int t;
      t = cap_n + n;
      for (int i = 0; i < 4000 && cap_n < t; i++)
         @(posedge clk);
      #1;
      if (cap_n < t)
         tally_and_finish(1);
   endtask
   task automatic t_codes();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk) #1;
         sel = adcc_sel_e'(i);
         raw = RAWS[i];
         wait_words(8);
         check(cap_word, {raw[13] ^ sel[1], raw[12:0]});
         check({13'h0, stab}, {13'h0, sel[1] ^ sel[0]});
      end
      $display("t_codes done");
   endtask
   task automatic t_sleep();
      int n;
      @(posedge clk) #1;
      sleep = 1'b1;
      repeat (10) @(posedge clk);
      n = cap_n;
      repeat (100) @(posedge clk);
      #1;
      check(14'(cap_n - n), 14'h0);
      check({12'h0, conv, ovf}, 14'h0);
      sclk_run = 1'b0;
      repeat (20) @(posedge clk) #1;
      sleep = 1'b0;
      sclk_run = 1'b1;
      wait_words(1);
      check({13'h0, cap_valid}, 14'h0);
      wait_words(30);
      check({13'h0, cap_valid}, 14'h1);
      check(cap_word, {raw[13] ^ sel[1], raw[12:0]});
      $display("t_sleep done");
   endtask
   task automatic t_reset();
      @(posedge clk) #1;
      rst_n = 1'b0;
      @(posedge clk) #1;
      check(bits, 14'h0);
      check({10'h0, strobe, stab, conv, ovf}, 14'h0);
      rst_n = 1'b1;
      wait_words(10);
      check(cap_word, {raw[13] ^ sel[1], raw[12:0]});
      check({13'h0, ovf}, 14'h0);
      $display("t_reset done");
   endtask
   initial
   begin
      rst_n = 1'b0;
      sleep = 1'b0;
      sel = ADCC_SEL_GND;
      raw = 14'h0;
      sclk_run = 1'b1;
      miscompares = 0;
      n_compared = 0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      t_codes();
      t_sleep();
      t_reset();
      tally_and_finish(0);
   end
endmodule
bind adcc_top adcc_chk #(.WIDTH(WIDTH)) adcc_chk_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
   .sleep_request_in(sleep_request_in), .format_stabilizer_select_in(format_stabilizer_select_in),
   .sample_bits_out(sample_bits_out), .sample_strobe_out(sample_strobe_out),
   .stabilizer_on_out(stabilizer_on_out), .converting_out(converting_out), .overflow_out(overflow_out));
`default_nettype wire
